//--- spz_regs.svh
`ifndef SPZ_REGS_SVH
`define SPZ_REGS_SVH
`define SPZ_ADDR_CONTROL 8'h98
`define SPZ_ADDR_BUFFER 8'h99
`define SPZ_ADDR_SLAVE 8'ha9
`define SPZ_ADDR_MASK 8'hb9
`define SPZ_ADDR_POWER 8'h87
`define SPZ_ADDR_IRQEN 8'ha8
`define SPZ_BIT_RI 0
`define SPZ_BIT_TI 1
`define SPZ_BIT_RB8 2
`define SPZ_BIT_TB8 3
`define SPZ_BIT_REN 4
`define SPZ_BIT_SM2 5
`define SPZ_BIT_SM1 6
`define SPZ_BIT_SM0 7
`define SPZ_BIT_DOUBLER 7
`define SPZ_BIT_FESEL 6
`define SPZ_BIT_GIE 7
`define SPZ_BIT_SIE 4
`define SPZ_RESET_BYTE 8'h00
`define SPZ_DIV_SLOW 8'd12
`define SPZ_DIV_FAST 8'd4
`define SPZ_DIV_M2 8'd64
`define SPZ_TICKS_PER_BIT 5'd16
`endif

//--- spz_pkg.sv
package spz_pkg;
	typedef enum logic [1:0]
	{
		SPZ_M0 = 2'b00,
		SPZ_M1 = 2'b01,
		SPZ_M2 = 2'b10,
		SPZ_M3 = 2'b11
	} spz_mode_e;
	typedef enum logic [1:0]
	{
		SPZ_IDLE = 2'b00,
		SPZ_BUSY = 2'b01,
		SPZ_STOP = 2'b10
	} spz_state_e;
endpackage

//--- spz_tick.sv
`timescale 1ns/1ns
`default_nettype none
`include "spz_regs.svh"
module spz_tick
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic restart,
	input wire logic ext_tick,
	input wire logic use_ext,
	input wire logic [7:0] div,
	output logic tick
);
	logic [7:0] cnt_r;
	// Bit-rate tick: fixed divider, or one tick per div external pulses
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || restart)
		begin
			cnt_r <= 8'h00;
			tick <= 1'b0;
		end
		else if (clk_en)
		begin
			tick <= 1'b0;
			if (!use_ext || ext_tick)
			begin
				if (cnt_r >= div - 8'h01)
				begin
					cnt_r <= 8'h00;
					tick <= 1'b1;
				end
				else
					cnt_r <= cnt_r + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

//--- spz_uart.sv
// Operation
// - Mode bits pick shift, 10-bit variable, 11-bit fixed, 11-bit variable.
// - Control bit 7 is mode high bit, or frame error when selected.
// - Frame error set by bad stop bit, cleared only by software.
// - Modes 2/3 with filter: no receive flag when ninth bit zero.
// - Mode 1 with filter: no receive flag without valid stop bit.
// - Mode 0 filter bit selects clock divide 12 or 4.
// - Reception only while receive enable is set.
// - Modes 2/3 send tx ninth bit as ninth data bit.
// - Rx ninth bit gets ninth bit, or stop bit in mode 1.
// - Transmit flag set after eighth bit or at stop start.
// - Receive flag set after eighth bit or mid stop, filtered.
// - Data address reads receive buffer, writes transmit buffer.
// - Address compare only on mask-set bits; zero mask accepts all.
// - Interrupt needs serial and global enables both set.
// - Baud doubler doubles the mode 2 rate only; mode 2 uses 32 not 64.
// - Transmit on serial_out_pin, receive on serial_in_pin.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "spz_regs.svh"
module spz_uart
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic baud_tick,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic serial_irq
);
	logic [7:0] ctrl_r;
	logic [7:0] rxbuf_r;
	logic [7:0] slave_addr_r;
	logic [7:0] mask_r;
	logic [7:0] power_r;
	logic [7:0] irqen_r;
	logic mode_hi_r;
	logic frame_err_r;
	logic [1:0] rx_sync_r;
	logic rx_in;
	spz_pkg::spz_mode_e mode;
	logic fesel;
	logic tx_tick;
	logic rx_tick;
	logic [7:0] div_sel;
	logic use_ext;
	spz_pkg::spz_state_e tx_st_r;
	logic [9:0] tx_sh_r;
	logic [3:0] tx_cnt_r;
	logic [3:0] tx_sub_r;
	logic tx_start;
	logic tx_bit_done;
	logic tx_set_ti;
	spz_pkg::spz_state_e rx_st_r;
	logic [8:0] rx_sh_r;
	logic [3:0] rx_cnt_r;
	logic [3:0] rx_sub_r;
	logic rx_prev_r;
	logic rx_mid;
	logic rx_set_ri;
	logic rx_bad_stop;
	logic [7:0] rx_byte;
	logic rx_ninth;
	logic rx_accept;
	logic sync_mode;

	assign fesel = power_r[`SPZ_BIT_FESEL];
	assign mode = spz_pkg::spz_mode_e'({mode_hi_r, ctrl_r[`SPZ_BIT_SM1]});
	assign sync_mode = (mode == spz_pkg::SPZ_M0);
	assign use_ext = mode[0] && !sync_mode;
	assign tx_start = clk_en && reg_wr && reg_addr == `SPZ_ADDR_BUFFER;

	// Per-bit rate divider shared by tx and rx; sub-bit counts run 16 ticks per bit in async modes
	always_comb
	begin
		div_sel = `SPZ_DIV_M2 >> 4;
		if (sync_mode)
			div_sel = ctrl_r[`SPZ_BIT_SM2] ? `SPZ_DIV_FAST : `SPZ_DIV_SLOW;
		else if (power_r[`SPZ_BIT_DOUBLER])
			div_sel = `SPZ_DIV_M2 >> 5;
	end

	// Mode 0 counts ticks 1:1 per bit; async modes divide each bit by 16
	function automatic logic bit_end(input logic s, input logic [3:0] sub);
		bit_end = s || sub == 4'hf;
	endfunction

	spz_tick u_tick
	(
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.restart(tx_start && sync_mode),
		.ext_tick(baud_tick),
		.use_ext(use_ext),
		.div(use_ext ? 8'h01 : div_sel),
		.tick(tx_tick)
	);
	assign rx_tick = tx_tick;

	// Pin synchroniser
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			rx_sync_r <= 2'h3;
		else if (clk_en)
			rx_sync_r <= {rx_sync_r[0], serial_in_pin};
	end
	assign rx_in = rx_sync_r[1];

	// Register writes
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			ctrl_r <= `SPZ_RESET_BYTE;
			slave_addr_r <= `SPZ_RESET_BYTE;
			mask_r <= `SPZ_RESET_BYTE;
			power_r <= `SPZ_RESET_BYTE;
			irqen_r <= `SPZ_RESET_BYTE;
			mode_hi_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (reg_wr && reg_addr == `SPZ_ADDR_CONTROL)
			begin
				ctrl_r[6:3] <= reg_wdata[6:3];
				if (!fesel)
					mode_hi_r <= reg_wdata[`SPZ_BIT_SM0];
			end
			if (reg_wr && reg_addr == `SPZ_ADDR_SLAVE)
				slave_addr_r <= reg_wdata;
			if (reg_wr && reg_addr == `SPZ_ADDR_MASK)
				mask_r <= reg_wdata;
			if (reg_wr && reg_addr == `SPZ_ADDR_POWER)
				power_r <= reg_wdata & 8'hc0;
			if (reg_wr && reg_addr == `SPZ_ADDR_IRQEN)
				irqen_r <= reg_wdata & 8'h90;
			// Set wins over clear for hardware flags
			if (rx_set_ri)
				ctrl_r[`SPZ_BIT_RB8] <= rx_ninth;
			if (tx_set_ti)
				ctrl_r[`SPZ_BIT_TI] <= 1'b1;
			else if (reg_wr && reg_addr == `SPZ_ADDR_CONTROL)
				ctrl_r[`SPZ_BIT_TI] <= reg_wdata[`SPZ_BIT_TI];
			if (rx_set_ri && rx_accept)
				ctrl_r[`SPZ_BIT_RI] <= 1'b1;
			else if (reg_wr && reg_addr == `SPZ_ADDR_CONTROL)
				ctrl_r[`SPZ_BIT_RI] <= reg_wdata[`SPZ_BIT_RI];
			if (reg_wr && reg_addr == `SPZ_ADDR_CONTROL && !rx_set_ri)
				ctrl_r[`SPZ_BIT_RB8] <= reg_wdata[`SPZ_BIT_RB8];
		end
	end

	// Frame error flag, software clears with a zero write
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			frame_err_r <= 1'b0;
		else if (clk_en)
		begin
			if (rx_set_ri && rx_bad_stop && !sync_mode)
				frame_err_r <= 1'b1;
			else if (reg_wr && reg_addr == `SPZ_ADDR_CONTROL && fesel)
				frame_err_r <= frame_err_r & reg_wdata[`SPZ_BIT_SM0];
		end
	end

	// Transmitter
	assign tx_bit_done = tx_tick && bit_end(sync_mode, tx_sub_r);
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			tx_st_r <= spz_pkg::SPZ_IDLE;
			tx_sh_r <= 10'h3ff;
			tx_cnt_r <= 4'h0;
			tx_sub_r <= 4'h0;
			serial_out_pin <= 1'b1;
			tx_set_ti <= 1'b0;
		end
		else if (clk_en)
		begin
			tx_set_ti <= 1'b0;
			unique case (tx_st_r)
				spz_pkg::SPZ_IDLE:
				begin
					serial_out_pin <= 1'b1;
					if (tx_start)
					begin
						tx_st_r <= spz_pkg::SPZ_BUSY;
						tx_sub_r <= 4'h0;
						if (sync_mode)
						begin
							tx_sh_r <= {2'b11, reg_wdata};
							tx_cnt_r <= 4'd8;
						end
						else
						begin
							tx_sh_r <= {ctrl_r[`SPZ_BIT_TB8], reg_wdata, 1'b0};
							tx_cnt_r <= mode[1] ? 4'd10 : 4'd9;
						end
					end
				end
				spz_pkg::SPZ_BUSY:
				begin
					serial_out_pin <= tx_sh_r[0];
					if (tx_tick)
						tx_sub_r <= tx_sub_r + 4'h1;
					if (tx_bit_done)
					begin
						tx_sh_r <= {1'b1, tx_sh_r[9:1]};
						tx_cnt_r <= tx_cnt_r - 4'h1;
						if (tx_cnt_r == 4'h1)
						begin
							tx_set_ti <= 1'b1;
							tx_st_r <= sync_mode ? spz_pkg::SPZ_IDLE : spz_pkg::SPZ_STOP;
						end
					end
				end
				spz_pkg::SPZ_STOP:
				begin
					serial_out_pin <= 1'b1;
					if (tx_tick)
						tx_sub_r <= tx_sub_r + 4'h1;
					if (tx_bit_done)
						tx_st_r <= spz_pkg::SPZ_IDLE;
				end
				default:
					tx_st_r <= spz_pkg::SPZ_IDLE;
			endcase
		end
	end

	// Receiver: async modes and mode 0; mode 0 shift reception samples the pin each bit
	assign rx_mid = rx_tick && (sync_mode || rx_sub_r == 4'h7);
	assign rx_byte = mode[1] ? rx_sh_r[7:0] : rx_sh_r[8:1];
	assign rx_ninth = mode[1] ? rx_sh_r[8] : rx_in;
	assign rx_bad_stop = !rx_in;
	assign rx_accept = sync_mode ? 1'b1 :
		!ctrl_r[`SPZ_BIT_SM2] ? 1'b1 :
		!mode[1] ? rx_in :
		(rx_sh_r[8] && ((rx_byte & mask_r) == (slave_addr_r & mask_r)));
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			rx_st_r <= spz_pkg::SPZ_IDLE;
			rx_sh_r <= 9'h000;
			rx_cnt_r <= 4'h0;
			rx_sub_r <= 4'h0;
			rx_prev_r <= 1'b1;
			rx_set_ri <= 1'b0;
			rxbuf_r <= 8'h00;
		end
		else if (clk_en)
		begin
			rx_set_ri <= 1'b0;
			rx_prev_r <= rx_in;
			unique case (rx_st_r)
				spz_pkg::SPZ_IDLE:
				begin
					rx_sub_r <= 4'h0;
					if (ctrl_r[`SPZ_BIT_REN])
					begin
						if (sync_mode && !ctrl_r[`SPZ_BIT_RI])
						begin
							rx_st_r <= spz_pkg::SPZ_BUSY;
							rx_cnt_r <= 4'd8;
						end
						else if (!sync_mode && rx_prev_r && !rx_in)
						begin
							rx_st_r <= spz_pkg::SPZ_BUSY;
							rx_cnt_r <= mode[1] ? 4'd11 : 4'd10;
						end
					end
				end
				spz_pkg::SPZ_BUSY:
				begin
					if (rx_tick)
						rx_sub_r <= rx_sub_r + 4'h1;
					if (!ctrl_r[`SPZ_BIT_REN])
						rx_st_r <= spz_pkg::SPZ_IDLE;
					else if (rx_mid)
					begin
						rx_cnt_r <= rx_cnt_r - 4'h1;
						if (rx_cnt_r == 4'h1)
						begin
							rx_st_r <= spz_pkg::SPZ_IDLE;
							rx_set_ri <= 1'b1;
						end
						else
							rx_sh_r <= {rx_in, rx_sh_r[8:1]};
						if (rx_cnt_r == 4'h1 && sync_mode)
							rx_sh_r <= {rx_in, rx_sh_r[8:1]};
					end
				end
				default:
					rx_st_r <= spz_pkg::SPZ_IDLE;
			endcase
			if (rx_set_ri && rx_accept)
				rxbuf_r <= sync_mode ? rx_sh_r[8:1] : rx_byte;
		end
	end

	// Read data and interrupt
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			reg_rdata <= 8'h00;
			serial_irq <= 1'b0;
		end
		else if (clk_en)
		begin
			serial_irq <= irqen_r[`SPZ_BIT_GIE] && irqen_r[`SPZ_BIT_SIE]
				&& (ctrl_r[`SPZ_BIT_TI] || ctrl_r[`SPZ_BIT_RI]);
			reg_rdata <= 8'h00;
			if (reg_rd)
			begin
				unique case (reg_addr)
					`SPZ_ADDR_CONTROL: reg_rdata <= {fesel ? frame_err_r : mode_hi_r, ctrl_r[6:0]};
					`SPZ_ADDR_BUFFER: reg_rdata <= rxbuf_r;
					`SPZ_ADDR_SLAVE: reg_rdata <= slave_addr_r;
					`SPZ_ADDR_MASK: reg_rdata <= mask_r;
					`SPZ_ADDR_POWER: reg_rdata <= power_r;
					`SPZ_ADDR_IRQEN: reg_rdata <= irqen_r;
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	a_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && !irqen_r[`SPZ_BIT_GIE]) |=> !serial_irq)
		else $error("irq without global enable");
	a_ti_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(ctrl_r[`SPZ_BIT_TI] && !(reg_wr && reg_addr == `SPZ_ADDR_CONTROL)) |=> ctrl_r[`SPZ_BIT_TI])
		else $error("transmit flag lost");
	a_ti_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && tx_set_ti) |=> ctrl_r[`SPZ_BIT_TI])
		else $error("transmit flag not set");
	a_rx_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rx_st_r == spz_pkg::SPZ_IDLE && !ctrl_r[`SPZ_BIT_REN]) |=> rx_st_r == spz_pkg::SPZ_IDLE)
		else $error("reception while disabled");
	a_fe_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(frame_err_r && !reg_wr) |=> frame_err_r)
		else $error("frame error lost");
	a_tx_idle_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(tx_st_r == spz_pkg::SPZ_IDLE && $past(tx_st_r) == spz_pkg::SPZ_IDLE && clk_en)
		|=> serial_out_pin)
		else $error("line not idle high");
	a_ri_filter: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && rx_set_ri && mode[1] && ctrl_r[`SPZ_BIT_SM2] && !rx_sh_r[8]
		&& !ctrl_r[`SPZ_BIT_RI] && !reg_wr) |=> !ctrl_r[`SPZ_BIT_RI])
		else $error("filtered frame flagged");
	a_buf_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && reg_rd && reg_addr == `SPZ_ADDR_BUFFER) |=> reg_rdata == $past(rxbuf_r))
		else $error("buffer read wrong");
endmodule
`default_nettype wire

//--- spz_peer.sv
`timescale 1ns/1ns
`default_nettype none
module spz_peer
(
	input wire logic ref_clk,
	input wire logic line_in,
	output logic line_out
);
	initial line_out = 1'b1;
	// Sends start, data LSB first, ninth bit, stop; idle high after
	task automatic send(input logic [7:0] d, input logic b9, input logic stp, input int bc);
		logic [10:0] f;
		f = {stp, b9, d, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			line_out <= f[i];
			repeat (bc) @(posedge ref_clk);
		end
		line_out <= 1'b1;
	endtask
	// Waits for start, samples each bit at its middle
	task automatic recv(input int bc, output logic [7:0] d, output logic b9);
		int n;
		n = 0;
		while (line_in !== 1'b0 && n < 4000)
		begin
			@(posedge ref_clk);
			n++;
		end
		repeat (bc / 2) @(posedge ref_clk);
		for (int i = 0; i < 9; i++)
		begin
			repeat (bc) @(posedge ref_clk);
			if (i < 8)
				d[i] = line_in;
			else
				b9 = line_in;
		end
	endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic ref_clk;
	logic rst_n;
	logic clk_en;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic baud_tick;
	logic rx_line;
	logic tx_line;
	logic serial_irq;
	logic [7:0] got;
	logic got9;
	logic [1:0] tdiv;
	int n_fail;
	int num_checks;
	int cyc;
	spz_uart spz_uart_inst
	(
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.baud_tick(baud_tick),
		.serial_in_pin(rx_line),
		.serial_out_pin(tx_line),
		.serial_irq(serial_irq)
	);
	spz_peer spz_peer_inst
	(
		.ref_clk(ref_clk),
		.line_in(tx_line),
		.line_out(rx_line)
	);
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		tdiv <= tdiv + 2'h1;
		baud_tick <= (tdiv == 2'h3);
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			summarize();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
		@(posedge ref_clk);
	endtask
	task automatic tx_frame(input logic [7:0] d, input int bc, input logic [7:0] e);
		fork
			spz_peer_inst.recv(bc, got, got9);
			wr(8'h99, d);
		join
		chk(got, e);
		chk({7'h0, got9}, 8'h01);
		repeat (2 * bc) @(posedge ref_clk);
		rd(8'h98, 8'h02, 8'h02);
	endtask
	task automatic rx_frame(input logic [7:0] d, input logic b9, input logic stp);
		spz_peer_inst.send(d, b9, stp, 64);
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		baud_tick = 1'b0;
		tdiv = 2'h0;
		n_fail = 0;
		num_checks = 0;
		cyc = 0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(8'h98, 8'hff, 8'h00);
		rd(8'h00, 8'hff, 8'h00);
		wr(8'ha9, 8'h5a);
		rd(8'ha9, 8'hff, 8'h5a);
		clk_en <= 1'b0;
		wr(8'ha9, 8'h00);
		clk_en <= 1'b1;
		rd(8'ha9, 8'hff, 8'h5a);
		wr(8'ha8, 8'h90);
		wr(8'h98, 8'h98);
		tx_frame(8'ha5, 64, 8'ha5);
		chk({7'h0, serial_irq}, 8'h01);
		wr(8'ha8, 8'h10);
		@(posedge ref_clk);
		chk({7'h0, serial_irq}, 8'h00);
		wr(8'h98, 8'h98);
		rx_frame(8'h3c, 1'b1, 1'b1);
		rd(8'h99, 8'hff, 8'h3c);
		rd(8'h98, 8'hff, 8'h9d);
		wr(8'h98, 8'hb8);
		rx_frame(8'h11, 1'b0, 1'b1);
		rd(8'h98, 8'h01, 8'h00);
		wr(8'hb9, 8'hff);
		rx_frame(8'h3c, 1'b1, 1'b1);
		rd(8'h98, 8'h01, 8'h00);
		rx_frame(8'h5a, 1'b1, 1'b1);
		rd(8'h98, 8'h01, 8'h01);
		wr(8'h98, 8'h88);
		rx_frame(8'h22, 1'b1, 1'b1);
		rd(8'h98, 8'h01, 8'h00);
		wr(8'h98, 8'h98);
		wr(8'h87, 8'h40);
		rx_frame(8'h44, 1'b1, 1'b0);
		rd(8'h98, 8'h80, 8'h80);
		wr(8'h98, 8'h18);
		rd(8'h98, 8'h80, 8'h00);
		wr(8'h87, 8'h80);
		rd(8'h98, 8'h80, 8'h80);
		wr(8'h98, 8'h98);
		tx_frame(8'h96, 32, 8'h96);
		wr(8'h98, 8'hd8);
		tx_frame(8'h5a, 64, 8'h5a);
		wr(8'h98, 8'h58);
		rx_frame(8'h69, 1'b1, 1'b1);
		rd(8'h99, 8'hff, 8'h69);
		rd(8'h98, 8'h05, 8'h05);
		wr(8'h98, 8'h78);
		rx_frame(8'h69, 1'b0, 1'b1);
		rd(8'h98, 8'h01, 8'h00);
		wr(8'h98, 8'h00);
		tx_frame(8'ha4, 12, 8'hd2);
		wr(8'h98, 8'h20);
		tx_frame(8'ha4, 4, 8'hd2);
		summarize();
	end
endmodule
`default_nettype wire
